/* bench/cas_host_model.sv */
// host model: drives the register strobes of the alarm block at the falling edge
`timescale 1ns/100ps
`default_nettype none
module cas_host_model (
    input wire logic clk_sys, // system clock
    output logic [7:0] reg_addr, // register offset
    output logic reg_wr_en, // write strobe
    output logic [7:0] reg_wr_data, // write data
    output logic reg_rd_en, // read strobe
    input wire logic [7:0] reg_rd_data, // read data
    input wire logic reg_rd_valid // read data valid
);
    // idle lines show the inverse of the last value, so stale data never looks right
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
    end

    // one-cycle write; a zero bit asks the device to clear that flag
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wr_data = ~d;
    endtask : wr

    // one-cycle read; the valid pulse is awaited for a bounded time only
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'hXX;
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (reg_rd_valid === 1'b1) begin
                d = reg_rd_data;
                ok = 1'b1;
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask : rd
endmodule : cas_host_model
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the clock alarm status and sticky flag block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end
module tb;
    typedef struct packed {logic [6:0] live; logic [7:0] e_live; logic [7:0] e_alarm;} cas_row_t;
    // live bits: 0 ref, 1 in1, 2 in2 missing, 3 unlock, 4 in1, 5 in2 offset, 6 hold valid
    localparam cas_row_t ROWS [8] = '{'{7'h01, 8'h01, 8'h00}, '{7'h02, 8'h02, 8'h00},
        '{7'h04, 8'h04, 8'h00}, '{7'h08, 8'h00, 8'h01}, '{7'h10, 8'h00, 8'h02},
        '{7'h20, 8'h00, 8'h04}, '{7'h40, 8'h00, 8'h40}, '{7'h7F, 8'h07, 8'h47}};
    logic clk_sys, rst_b, reg_wr_en, reg_rd_en, reg_rd_valid, ok;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, rdv;
    logic [6:0] live_v;
    logic [5:0] mask_v;
    logic int_pin_enable, input1_selected, irq_out, input1_active_indicator;
    int err_count = 0;
    int n_checks = 0;

    cas_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid));

    cas_alarm_status dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
        .in2_signal_missing_live(live_v[2]), .in1_signal_missing_live(live_v[1]),
        .ref_signal_missing_live(live_v[0]), .hold_history_valid(live_v[6]),
        .in2_freq_offset_live(live_v[5]), .in1_freq_offset_live(live_v[4]),
        .pll_unlock_live(live_v[3]), .in2_signal_missing_mask(mask_v[2]),
        .in1_signal_missing_mask(mask_v[1]), .ref_signal_missing_mask(mask_v[0]),
        .in2_freq_offset_mask(mask_v[5]), .in1_freq_offset_mask(mask_v[4]),
        .pll_unlock_mask(mask_v[3]), .int_pin_enable(int_pin_enable),
        .input1_selected(input1_selected), .irq_out(irq_out),
        .input1_active_indicator(input1_active_indicator));

    // 125 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    // read and compare; a missing valid pulse ends the run rather than hanging
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rdv, ok);
        if (!ok) begin
            err_count++;
            wrap_up();
        end else begin
            `CHK(rdv, e)
        end
    endtask : rchk

    // watchdog for any hang
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        live_v = 7'h7F;
        mask_v = 6'h3F;
        int_pin_enable = 1'b0;
        input1_selected = 1'b0;
        // alarms present during reset must not leave flags behind
        repeat (6) @(negedge clk_sys);
        `CHK(irq_out, 1'b0)
        rst_b = 1'b1;
        live_v = 7'h00;
        rchk(8'h83, 8'h00);
        rchk(8'h84, 8'h00);
        // live register rows; the last row also sets every flag
        foreach (ROWS[i]) begin
            live_v = ROWS[i].live;
            rchk(8'h81, ROWS[i].e_live);
            rchk(8'h82, ROWS[i].e_alarm);
        end
        live_v = 7'h00;
        rchk(8'h83, 8'h07);
        rchk(8'h84, 8'h0E);
        host.wr(8'h83, 8'hFF);
        host.wr(8'h84, 8'hFF);
        rchk(8'h84, 8'h0E);
        rchk(8'h85, 8'h00);
        host.wr(8'h81, 8'h00);
        rchk(8'h83, 8'h07);
        rchk(8'h81, 8'h00);
        host.wr(8'h83, 8'h05);
        rchk(8'h83, 8'h05);
        host.wr(8'h84, 8'h01);
        rchk(8'h84, 8'h00);
        host.wr(8'h83, 8'h00);
        // clear while the alarm is still live: set must win
        live_v = 7'h08;
        host.wr(8'h84, 8'h00);
        rchk(8'h84, 8'h02);
        live_v = 7'h00;
        host.wr(8'h84, 8'h00);
        rchk(8'h84, 8'h00);
        // each flag alone against its own mask and the pin enable
        int_pin_enable = 1'b1;
        for (int i = 0; i < 6; i++) begin
            mask_v = ~(6'h01 << i);
            live_v = {1'b0, 6'h01 << i};
            @(negedge clk_sys);
            live_v = 7'h00;
            @(negedge clk_sys);
            `CHK(irq_out, 1'b1)
            mask_v = 6'h3F;
            @(negedge clk_sys);
            `CHK(irq_out, 1'b0)
            mask_v = 6'h00;
            int_pin_enable = 1'b0;
            @(negedge clk_sys);
            `CHK(irq_out, 1'b0)
            int_pin_enable = 1'b1;
            host.wr(cas_pkg::FLAG_OFS[i], 8'h00);
            @(negedge clk_sys);
            `CHK(irq_out, 1'b0)
        end
        // input 1 active only while selected and not missing
        input1_selected = 1'b1;
        @(negedge clk_sys);
        `CHK(input1_active_indicator, 1'b1)
        live_v = 7'h02;
        @(negedge clk_sys);
        `CHK(input1_active_indicator, 1'b0)
        live_v = 7'h00;
        input1_selected = 1'b0;
        @(negedge clk_sys);
        `CHK(input1_active_indicator, 1'b0)
        // reset in mid-run must clear flags that alarms have set
        live_v = 7'h7F;
        @(negedge clk_sys);
        live_v = 7'h00;
        rchk(8'h83, 8'h07);
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        rchk(8'h83, 8'h00);
        rchk(8'h84, 8'h00);
        wrap_up();
    end
endmodule : tb
`default_nettype wire

/* hdl/cas_alarm_status.sv */
// alarm live status, sticky flag registers and interrupt pin
`timescale 1ns/100ps
`default_nettype none
module cas_alarm_status (
    input wire logic clk_sys, // system clock, 125 MHz
    input wire logic rst_b, // synchronous reset, active low
    // register access from the management port
    input wire logic [7:0] reg_addr, // register offset
    input wire logic reg_wr_en, // write strobe, one cycle
    input wire logic [7:0] reg_wr_data, // write data
    input wire logic reg_rd_en, // read strobe, one cycle
    output logic [7:0] reg_rd_data, // read data, held until next read
    output logic reg_rd_valid, // read data valid pulse
    // live alarms from the detectors
    input wire logic in2_signal_missing_live, // input 2 signal lost
    input wire logic in1_signal_missing_live, // input 1 signal lost
    input wire logic ref_signal_missing_live, // reference oscillator lost
    input wire logic hold_history_valid, // hold history filled
    input wire logic in2_freq_offset_live, // input 2 offset alarm
    input wire logic in1_freq_offset_live, // input 1 offset alarm
    input wire logic pll_unlock_live, // pll not locked
    // mask and enable settings held elsewhere
    input wire logic in2_signal_missing_mask, // mask, 1 suppresses
    input wire logic in1_signal_missing_mask, // mask, 1 suppresses
    input wire logic ref_signal_missing_mask, // mask, 1 suppresses
    input wire logic in2_freq_offset_mask, // mask, 1 suppresses
    input wire logic in1_freq_offset_mask, // mask, 1 suppresses
    input wire logic pll_unlock_mask, // mask, 1 suppresses
    input wire logic int_pin_enable, // interrupt pin enable
    input wire logic input1_selected, // input 1 chosen as pll input
    output logic irq_out, // interrupt pin, active high
    output logic input1_active_indicator // input 1 really active
);
    logic [5:0] live_vec;
    logic [5:0] mask_vec;
    logic [5:0] flags;
    logic [5:0] clear_vec;
    logic [7:0] live_in_byte;
    logic [7:0] live_pll_byte;
    logic [7:0] sticky_in_byte;
    logic [7:0] sticky_pll_byte;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic act1_reg;
    logic act1_next;

    // gather live alarms and masks in flag index order
    always_comb begin
        live_vec = '0;
        live_vec[cas_pkg::FLAG_REF_MISSING] = ref_signal_missing_live;
        live_vec[cas_pkg::FLAG_IN1_MISSING] = in1_signal_missing_live;
        live_vec[cas_pkg::FLAG_IN2_MISSING] = in2_signal_missing_live;
        live_vec[cas_pkg::FLAG_PLL_UNLOCK] = pll_unlock_live;
        live_vec[cas_pkg::FLAG_IN1_OFFSET] = in1_freq_offset_live;
        live_vec[cas_pkg::FLAG_IN2_OFFSET] = in2_freq_offset_live;
        mask_vec = '0;
        mask_vec[cas_pkg::FLAG_REF_MISSING] = ref_signal_missing_mask;
        mask_vec[cas_pkg::FLAG_IN1_MISSING] = in1_signal_missing_mask;
        mask_vec[cas_pkg::FLAG_IN2_MISSING] = in2_signal_missing_mask;
        mask_vec[cas_pkg::FLAG_PLL_UNLOCK] = pll_unlock_mask;
        mask_vec[cas_pkg::FLAG_IN1_OFFSET] = in1_freq_offset_mask;
        mask_vec[cas_pkg::FLAG_IN2_OFFSET] = in2_freq_offset_mask;
    end

    // one sticky flag per alarm; a write of 1 never clears
    generate
        for (genvar i = 0; i < 6; i++) begin : g_flag
            assign clear_vec[i] = reg_wr_en && (reg_addr == cas_pkg::FLAG_OFS[i])
                && !reg_wr_data[cas_pkg::FLAG_BIT[i]];
            cas_sticky_flag u_flag (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .live(live_vec[i]),
                .clear_req(clear_vec[i]),
                .flag(flags[i])
            );
        end
    endgenerate

    cas_irq_gate u_irq (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .flags(flags),
        .mask(mask_vec),
        .int_pin_enable(int_pin_enable),
        .irq(irq_out)
    );

    // register images; reserved bits stay zero
    always_comb begin
        live_in_byte = 8'h00;
        live_in_byte[cas_pkg::IN2_MISSING_BIT] = in2_signal_missing_live;
        live_in_byte[cas_pkg::IN1_MISSING_BIT] = in1_signal_missing_live;
        live_in_byte[cas_pkg::REF_MISSING_BIT] = ref_signal_missing_live;
        live_pll_byte = 8'h00;
        live_pll_byte[cas_pkg::HOLD_VALID_BIT] = hold_history_valid;
        live_pll_byte[cas_pkg::IN2_OFFSET_BIT] = in2_freq_offset_live;
        live_pll_byte[cas_pkg::IN1_OFFSET_BIT] = in1_freq_offset_live;
        live_pll_byte[cas_pkg::PLL_UNLOCK_BIT] = pll_unlock_live;
        sticky_in_byte = 8'h00;
        sticky_pll_byte = 8'h00;
        for (int k = 0; k < 6; k++) begin
            if (cas_pkg::FLAG_OFS[k] == cas_pkg::INPUT_SIGNAL_STICKY_FLAGS_OFS) begin
                sticky_in_byte[cas_pkg::FLAG_BIT[k]] = flags[k];
            end else begin
                sticky_pll_byte[cas_pkg::FLAG_BIT[k]] = flags[k];
            end
        end
    end

    // read port: data one cycle after the strobe, unmapped offsets read zero
    always_comb begin
        rd_data_next = rd_data_reg;
        rd_valid_next = reg_rd_en;
        if (reg_rd_en) begin
            case (reg_addr)
                cas_pkg::INPUT_SIGNAL_LIVE_STATUS_OFS: rd_data_next = live_in_byte;
                cas_pkg::PLL_ALARM_LIVE_STATUS_OFS: rd_data_next = live_pll_byte;
                cas_pkg::INPUT_SIGNAL_STICKY_FLAGS_OFS: rd_data_next = sticky_in_byte;
                cas_pkg::PLL_ALARM_STICKY_FLAGS_OFS: rd_data_next = sticky_pll_byte;
                default: rd_data_next = 8'h00;
            endcase
        end
        // a lost signal can never be the active input, whatever is selected
        act1_next = input1_selected && !in1_signal_missing_live;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_data_reg <= cas_pkg::RD_DATA_RESET;
            rd_valid_reg <= 1'h0;
            act1_reg <= 1'h0;
        end else begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            act1_reg <= act1_next;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;
    assign input1_active_indicator = act1_reg;

    // checks on the registered outputs and the flags
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_rd(logic [7:0] ofs);
        reg_rd_en && reg_addr == ofs;
    endsequence

    property p_live_in_read;
        s_rd(cas_pkg::INPUT_SIGNAL_LIVE_STATUS_OFS) |=> reg_rd_valid
            && reg_rd_data == {5'h00, $past(in2_signal_missing_live),
            $past(in1_signal_missing_live), $past(ref_signal_missing_live)};
    endproperty
    a_live_in_read: assert property (p_live_in_read)
        else $error("live input status read wrong");

    property p_live_pll_read;
        s_rd(cas_pkg::PLL_ALARM_LIVE_STATUS_OFS) |=> reg_rd_data ==
            {1'h0, $past(hold_history_valid), 3'h0, $past(in2_freq_offset_live),
            $past(in1_freq_offset_live), $past(pll_unlock_live)};
    endproperty
    a_live_pll_read: assert property (p_live_pll_read)
        else $error("live alarm status read wrong");

    property p_sticky_in_read;
        s_rd(cas_pkg::INPUT_SIGNAL_STICKY_FLAGS_OFS) |=>
            reg_rd_data == {5'h00, $past(flags[2:0])};
    endproperty
    a_sticky_in_read: assert property (p_sticky_in_read)
        else $error("sticky input flags read wrong");

    property p_sticky_pll_read;
        s_rd(cas_pkg::PLL_ALARM_STICKY_FLAGS_OFS) |=>
            reg_rd_data == {4'h0, $past(flags[5:3]), 1'h0};
    endproperty
    a_sticky_pll_read: assert property (p_sticky_pll_read)
        else $error("sticky alarm flags read wrong");

    property p_flag_hold;
        live_vec != 6'h00 ##1 live_vec == 6'h00 && !reg_wr_en
            |=> (flags & $past(live_vec, 2)) == $past(live_vec, 2);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("sticky flag dropped after alarm went away");

    property p_clear_zero;
        reg_wr_en && reg_addr == cas_pkg::INPUT_SIGNAL_STICKY_FLAGS_OFS
            && reg_wr_data == 8'h00 && live_vec[2:0] == 3'h0
            |=> flags[2:0] == 3'h0;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("write of 0 did not clear input flags");

    property p_write_one_keeps;
        reg_wr_en && reg_addr == cas_pkg::PLL_ALARM_STICKY_FLAGS_OFS
            && reg_wr_data == 8'hFF
            |=> flags[5:3] == ($past(flags[5:3]) | $past(live_vec[5:3]));
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("write of 1 changed a flag");

    property p_set_wins;
        (live_vec & clear_vec) != 6'h00 |=> (flags & $past(live_vec) & $past(clear_vec))
            == ($past(live_vec) & $past(clear_vec));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("live alarm lost under a clear");

    property p_irq;
        ##1 irq_out == ($past(int_pin_enable) && (|($past(flags) & ~$past(mask_vec))));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt pin does not follow masked flags");

    property p_masked_quiet;
        (flags & ~mask_vec) == 6'h00 [*2] |-> !irq_out;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("masked flag raised the interrupt");

    property p_act1;
        in1_signal_missing_live |=> !input1_active_indicator;
    endproperty
    a_act1: assert property (p_act1)
        else $error("input 1 shown active while signal missing");

    property p_reset_clear;
        !$past(rst_b) |-> flags == 6'h00 && !irq_out && !reg_rd_valid;
    endproperty
    a_reset_clear: assert property (@(posedge clk_sys) p_reset_clear)
        else $error("flags not cleared by reset");

    // writes that must not clear anything
    property p_live_write_ignored;
        reg_wr_en && (reg_addr == cas_pkg::INPUT_SIGNAL_LIVE_STATUS_OFS
            || reg_addr == cas_pkg::PLL_ALARM_LIVE_STATUS_OFS)
            |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_live_write_ignored: assert property (p_live_write_ignored)
        else $error("write to a live register cleared a flag");

    property p_in_write_one_keeps;
        reg_wr_en && reg_addr == cas_pkg::INPUT_SIGNAL_STICKY_FLAGS_OFS
            && reg_wr_data[2:0] == 3'h7
            |=> flags[2:0] == ($past(flags[2:0]) | $past(live_vec[2:0]));
    endproperty
    a_in_write_one_keeps: assert property (p_in_write_one_keeps)
        else $error("write of 1 changed an input flag");

    // without a write no flag ever falls, whatever the live alarms do
    property p_no_drop;
        !reg_wr_en |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_no_drop: assert property (p_no_drop)
        else $error("sticky flag fell without a clear");

    property p_flag_set;
        live_vec != 6'h00 |=> (flags & $past(live_vec)) == $past(live_vec);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("live alarm did not set its flag");

    property p_clear_pll;
        reg_wr_en && reg_addr == cas_pkg::PLL_ALARM_STICKY_FLAGS_OFS
            && reg_wr_data[3:1] == 3'h0 && live_vec[5:3] == 3'h0
            |=> flags[5:3] == 3'h0;
    endproperty
    a_clear_pll: assert property (p_clear_pll)
        else $error("write of 0 did not clear alarm flags");

    // interrupt pin and input 1 indicator
    property p_irq_off;
        !int_pin_enable |=> !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt raised with the pin disabled");

    property p_act1_on;
        input1_selected && !in1_signal_missing_live |=> input1_active_indicator;
    endproperty
    a_act1_on: assert property (p_act1_on)
        else $error("selected healthy input 1 not shown active");

    property p_cv_flag_cleared;
        flags[3] ##1 clear_vec[3] && !live_vec[3] ##1 !flags[3];
    endproperty
    c_flag_cleared: cover property (p_cv_flag_cleared);

    property p_cv_irq_rise;
        !irq_out ##1 irq_out;
    endproperty
    c_irq_rise: cover property (p_cv_irq_rise);

    property p_cv_sticky_read;
        s_rd(cas_pkg::INPUT_SIGNAL_STICKY_FLAGS_OFS) ##1 reg_rd_data != 8'h00;
    endproperty
    c_sticky_read: cover property (p_cv_sticky_read);

    property p_cv_set_wins;
        (live_vec & clear_vec) != 6'h00;
    endproperty
    c_set_wins: cover property (p_cv_set_wins);
endmodule : cas_alarm_status
`default_nettype wire

/* hdl/cas_irq_gate.sv */
// masks the sticky flags onto the registered interrupt pin
`timescale 1ns/100ps
`default_nettype none
module cas_irq_gate (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [5:0] flags, // sticky flags
    input wire logic [5:0] mask, // 1 suppresses the flag
    input wire logic int_pin_enable, // interrupt pin enable
    output logic irq // interrupt, active high
);
    logic irq_reg;
    logic irq_next;

    // a masked flag still latches upstream; it only drops out here
    always_comb begin
        irq_next = int_pin_enable && (|(flags & ~mask));
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_reg <= 1'h0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign irq = irq_reg;
endmodule : cas_irq_gate
`default_nettype wire

/* hdl/cas_sticky_flag.sv */
// one sticky alarm flag with host clear-by-zero
`timescale 1ns/100ps
`default_nettype none
module cas_sticky_flag (
    input wire logic clk_sys, // system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic live, // live alarm level
    input wire logic clear_req, // host wrote 0 to this bit
    output logic flag // held alarm
);
    logic flag_reg;
    logic flag_next;

    // set wins over clear so an alarm present at the clear is never lost
    always_comb begin
        flag_next = flag_reg;
        if (clear_req) begin
            flag_next = 1'h0;
        end
        if (live) begin
            flag_next = 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            flag_reg <= cas_pkg::FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;
endmodule : cas_sticky_flag
`default_nettype wire

/* include/cas_pkg.sv */
// constants shared by the clock alarm status and sticky flag logic
package cas_pkg;
    localparam int unsigned NUM_FLAGS = 32'h6;

    // register offsets on the management port
    localparam logic [7:0] INPUT_SIGNAL_LIVE_STATUS_OFS = 8'h81;
    localparam logic [7:0] PLL_ALARM_LIVE_STATUS_OFS = 8'h82;
    localparam logic [7:0] INPUT_SIGNAL_STICKY_FLAGS_OFS = 8'h83;
    localparam logic [7:0] PLL_ALARM_STICKY_FLAGS_OFS = 8'h84;

    // reset values
    localparam logic [7:0] RD_DATA_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'h0;

    // bit positions in the live registers
    localparam int unsigned REF_MISSING_BIT = 32'h0;
    localparam int unsigned IN1_MISSING_BIT = 32'h1;
    localparam int unsigned IN2_MISSING_BIT = 32'h2;
    localparam int unsigned PLL_UNLOCK_BIT = 32'h0;
    localparam int unsigned IN1_OFFSET_BIT = 32'h1;
    localparam int unsigned IN2_OFFSET_BIT = 32'h2;
    localparam int unsigned HOLD_VALID_BIT = 32'h6;

    // sticky flag index: 0 ref, 1 in1, 2 in2 missing, 3 unlock, 4 in1, 5 in2 offset
    localparam int unsigned FLAG_REF_MISSING = 32'h0;
    localparam int unsigned FLAG_IN1_MISSING = 32'h1;
    localparam int unsigned FLAG_IN2_MISSING = 32'h2;
    localparam int unsigned FLAG_PLL_UNLOCK = 32'h3;
    localparam int unsigned FLAG_IN1_OFFSET = 32'h4;
    localparam int unsigned FLAG_IN2_OFFSET = 32'h5;

    // register and bit position of each sticky flag
    localparam logic [7:0] FLAG_OFS [NUM_FLAGS] = '{
        INPUT_SIGNAL_STICKY_FLAGS_OFS, INPUT_SIGNAL_STICKY_FLAGS_OFS,
        INPUT_SIGNAL_STICKY_FLAGS_OFS, PLL_ALARM_STICKY_FLAGS_OFS,
        PLL_ALARM_STICKY_FLAGS_OFS, PLL_ALARM_STICKY_FLAGS_OFS};
    localparam int unsigned FLAG_BIT [NUM_FLAGS] = '{
        32'h0, 32'h1, 32'h2, 32'h1, 32'h2, 32'h3};
endpackage : cas_pkg
